// *** core/csi_core.sv ***
// Card command interpreter: serial frame capture, decode and response
// Behaviour
// (R1) Power-on or reset command enters idle
// (R2) Idle accepts only init and conditions read; the code also accepts reset while idle
// (R3) Init takes no operand, no conditions data
// (R4) Conditions read accepted at any time
// (R5) Host repeats init until idle clears
// (R6) Every command gets an accept/reject response
// (R7) Reject bad opcode, CRC, operand
// (R8) Lock answers short response then busy
// (R9) Frames are six bytes, MSB first
// (R10) Fixed start, index, argument, CRC, end fields
// (R11) Seven-bit CRC over first forty bits
// (R12) Index field holds command number binary
// (R13) Host zeroes unused argument field
// (R14) Only listed indices supported
// (R15) Specific-data and identity reads, short response
// (R16) Status fetch uses two-byte response
// (R17) Block length command sets later lengths
// (R18) Single read at argument address
// (R19) Multi read until stop or count; the code has no stop command and only hands the count to the back end
// (R20) Block count: high half zero, applies next
// (R21) Single write, short response then busy
// (R22) Init starts internal initialisation
// (R23) Busy follows short response until done
// (R24) Data output held low while busy
// (R25) Unsupported index answered illegal, no action
`timescale 1ns/1ps
`default_nettype none
`include "csi_cfg.svh"
module csi_core #(
  parameter int INIT_CYCLES = `CSI_INIT_CYC,
  parameter int MAX_BLK_LEN = `CSI_MAX_BLK_LEN,
  parameter logic [31:0] OCR_VALUE = `CSI_OCR_RST
) (
  // System clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Serial link, clocked by the host
  input wire logic link_clk_i,
  input wire logic link_cs_b_i,
  input wire logic link_mosi_i,
  output logic serial_data_output_o,
  output logic serial_data_output_oe_o,
  // Configuration and status
  input wire logic crc_check_en_i,
  input wire logic [7:0] status_byte_i,
  output logic card_idle_o,
  output logic card_busy_o,
  // Actions toward the storage back end
  output csi_pkg::csi_cmd_act_t cmd_act_o,
  input wire logic op_done_i
);

  ////////////////////////////////////////////////////////////////////
  // Parameter checks

  // Counter width limits the init time; block length must be positive
  if (INIT_CYCLES < 1 || INIT_CYCLES > 65535) begin : g_bad_init
    $error("INIT_CYCLES out of range");
  end
  if (MAX_BLK_LEN < 1) begin : g_bad_len
    $error("MAX_BLK_LEN must be positive");
  end

  ////////////////////////////////////////////////////////////////////
  // Decode helpers

  // CRC7, polynomial x^7 + x^3 + 1, MSB first
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    logic fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c = {c[5:0], fb};
      c[3] = c[3] ^ fb;
    end
    return c;
  endfunction

  // Indices this card serves
  function automatic logic supported(input logic [5:0] c);
    unique case (c)
      `CSI_CMD_RESET, `CSI_CMD_INIT, `CSI_CMD_CSD, `CSI_CMD_CID,
      `CSI_CMD_STATUS, `CSI_CMD_BLKLEN, `CSI_CMD_RD_ONE,
      `CSI_CMD_RD_MULTI, `CSI_CMD_BLKCNT, `CSI_CMD_WR_ONE,
      `CSI_CMD_LOCK, `CSI_CMD_OCR: supported = 1'b1;
      default: supported = 1'b0;
    endcase
  endfunction

  // Indices legal while the card is idle
  function automatic logic idle_legal(input logic [5:0] c);
    idle_legal = (c == `CSI_CMD_RESET) || (c == `CSI_CMD_INIT) ||
                 (c == `CSI_CMD_OCR);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // State

  csi_pkg::csi_link_t l; // Link domain state
  csi_pkg::csi_link_t l_n; // Its next value
  csi_pkg::csi_sys_t s; // System domain state
  csi_pkg::csi_sys_t s_n; // Its next value

  ////////////////////////////////////////////////////////////////////
  // Frame decode, system side

  logic take; // New frame arrived from link
  logic [47:0] frm; // Frame, stable while link waits
  logic [5:0] idx; // Command index
  logic [31:0] arg; // Argument
  logic crc_bad; // CRC mismatch while checking is on
  logic frame_bad; // Transmission or end bit wrong
  logic illegal; // Unsupported, malformed frame or not allowed now
  logic param_err; // Operand out of range
  logic bad; // Any reason to reject
  logic [7:0] r1; // Short response byte

  // Toggle edge after the two-flop synchroniser
  assign take = s.ftg_s ^ s.ftg_d;
  assign frm = l.frame;
  assign idx = frm[`CSI_IDX_HI:`CSI_IDX_LO]; // R12
  assign arg = frm[`CSI_ARG_HI:`CSI_ARG_LO];
  // Check only while crc_check_en_i is set, otherwise unprotected mode
  assign crc_bad = crc_check_en_i &&
    (crc7(frm[47:8]) != frm[`CSI_CRC_HI:`CSI_CRC_LO]); // R11
  assign frame_bad = !frm[`CSI_TX_BIT] || !frm[`CSI_END_BIT]; // R10
  assign illegal = !supported(idx) || frame_bad ||
    (s.idle && !idle_legal(idx)); // R2 R14 R25
  assign param_err =
    ((idx == `CSI_CMD_BLKCNT) && (arg[31:16] != 16'h0000)) || // R20
    ((idx == `CSI_CMD_BLKLEN) &&
     ((arg == 32'h00000000) || (arg > 32'(MAX_BLK_LEN))));
  assign bad = illegal || crc_bad || param_err; // R7

  ////////////////////////////////////////////////////////////////////
  // System domain next state

  always_comb begin
    s_n = s;
    r1 = 8'h00;
    // Frame toggle synchroniser
    s_n.ftg_m = l.ftg;
    s_n.ftg_s = s.ftg_m;
    s_n.ftg_d = s.ftg_s;
    // Action is a one-cycle pulse
    s_n.act.valid = 1'b0;
    // Internal initialisation countdown
    if (s.init_run) begin
      if (s.init_cnt <= 16'h0001) begin
        s_n.init_run = 1'b0;
        s_n.idle = 1'b0;
      end else begin
        s_n.init_cnt = s.init_cnt - 16'h0001;
      end
    end
    // Back end reports end of programming
    if (op_done_i) begin
      s_n.busy = 1'b0; // R23
    end
    // Frame handling
    if (take) begin
      s_n.rtg = ~s.rtg; // R6
      s_n.rsp.nbytes = 3'h1;
      s_n.rsp.busy = 1'b0;
      // Block count applies to the next command only
      s_n.pend_vld = 1'b0; // R20
      s_n.act.addr = arg;
      s_n.act.blk_len = s.blk_len;
      s_n.act.blk_cnt = 16'h0000;
      if (!bad) begin
        unique case (idx)
          // Software reset, also aborts programming
          `CSI_CMD_RESET: begin
            s_n.idle = 1'b1; // R1
            s_n.init_run = 1'b0;
            s_n.busy = 1'b0;
          end
          // Start initialisation once, repeats only poll
          `CSI_CMD_INIT: begin
            if (s.idle && !s.init_run) begin
              s_n.init_run = 1'b1; // R22 R3
              s_n.init_cnt = 16'(INIT_CYCLES);
            end
          end
          // Register reads done by the back end as data blocks
          `CSI_CMD_CSD: begin
            s_n.act.valid = 1'b1; // R15
            s_n.act.kind = csi_pkg::ACT_CSD;
          end
          `CSI_CMD_CID: begin
            s_n.act.valid = 1'b1; // R15
            s_n.act.kind = csi_pkg::ACT_CID;
          end
          // Status carried in the second byte
          `CSI_CMD_STATUS: begin
            s_n.rsp.nbytes = 3'h2; // R16
          end
          // New block length for later transfers
          `CSI_CMD_BLKLEN: begin
            s_n.blk_len = arg; // R17
          end
          `CSI_CMD_RD_ONE: begin
            s_n.act.valid = 1'b1; // R18
            s_n.act.kind = csi_pkg::ACT_RD_ONE;
          end
          // Count zero means open ended
          `CSI_CMD_RD_MULTI: begin
            s_n.act.valid = 1'b1; // R19
            s_n.act.kind = csi_pkg::ACT_RD_MULTI;
            s_n.act.blk_cnt = s.pend_vld ? s.pend_cnt : 16'h0000;
          end
          `CSI_CMD_BLKCNT: begin
            s_n.pend_vld = 1'b1; // R20
            s_n.pend_cnt = arg[15:0];
          end
          // Writes and lock hold busy until the back end is done
          `CSI_CMD_WR_ONE: begin
            s_n.act.valid = 1'b1; // R21
            s_n.act.kind = csi_pkg::ACT_WR_ONE;
            s_n.busy = 1'b1;
            s_n.rsp.busy = 1'b1;
          end
          `CSI_CMD_LOCK: begin
            s_n.act.valid = 1'b1; // R8
            s_n.act.kind = csi_pkg::ACT_LOCK;
            s_n.busy = 1'b1;
            s_n.rsp.busy = 1'b1;
          end
          // Conditions register follows the short response
          `CSI_CMD_OCR: begin
            s_n.rsp.nbytes = 3'h5; // R4
          end
          default: begin
          end
        endcase
      end
      // Short response reflects the state after the command
      r1[`CSI_RB_IDLE] = s_n.idle; // R5
      r1[`CSI_RB_ILLEGAL] = illegal; // R25
      r1[`CSI_RB_CRC] = crc_bad;
      r1[`CSI_RB_PARAM] = param_err;
      if (idx == `CSI_CMD_OCR) begin
        s_n.rsp.bytes = {r1, OCR_VALUE};
      end else begin
        s_n.rsp.bytes = {r1, status_byte_i, 24'h000000};
      end
    end
  end

  // System registers, synchronous reset
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      s <= '0;
      s.idle <= 1'b1; // R1
      s.blk_len <= `CSI_BLK_LEN_RST;
    end else begin
      s <= s_n;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Link domain next state

  always_comb begin
    l_n = l;
    // Reset and crossing synchronisers
    l_n.rst_m = rst_b_i;
    l_n.rst_s = l.rst_m;
    l_n.rtg_m = s.rtg;
    l_n.rtg_s = l.rtg_m;
    l_n.rtg_d = l.rtg_s;
    l_n.bsy_m = s.busy;
    l_n.bsy_s = l.bsy_m;
    unique case (l.st)
      // Line idles high, start bit opens a frame
      csi_pkg::L_HUNT: begin
        l_n.miso = 1'b1;
        if (!link_cs_b_i && !link_mosi_i) begin
          l_n.st = csi_pkg::L_CMD;
          l_n.frame = 48'h000000000000;
          l_n.bcnt = 6'h01;
        end
      end
      // Shift in the remaining 47 bits, MSB first
      csi_pkg::L_CMD: begin
        if (link_cs_b_i) begin
          l_n.st = csi_pkg::L_HUNT;
        end else begin
          l_n.frame = {l.frame[46:0], link_mosi_i}; // R9
          l_n.bcnt = l.bcnt + 6'h01;
          if (l.bcnt == `CSI_FRM_LAST) begin
            l_n.ftg = ~l.ftg;
            l_n.st = csi_pkg::L_WAIT;
          end
        end
      end
      // Fill with ones until the answer crosses over
      csi_pkg::L_WAIT: begin
        l_n.miso = 1'b1;
        if (l.rtg_s ^ l.rtg_d) begin
          l_n.miso = s.rsp.bytes[39];
          l_n.osh = {s.rsp.bytes[38:0], 1'b0};
          l_n.bcnt = {s.rsp.nbytes, 3'b000} - 6'h01;
          l_n.st = csi_pkg::L_RSP;
        end
      end
      // Shift out the response bytes
      csi_pkg::L_RSP: begin
        if (l.bcnt == 6'h00) begin
          l_n.miso = !l.bsy_s; // R23
          l_n.st = l.bsy_s ? csi_pkg::L_BUSY : csi_pkg::L_HUNT;
        end else begin
          l_n.miso = l.osh[39];
          l_n.osh = {l.osh[38:0], 1'b0};
          l_n.bcnt = l.bcnt - 6'h01;
        end
      end
      // Line held low until programming ends
      csi_pkg::L_BUSY: begin
        l_n.miso = 1'b0; // R24
        if (!l.bsy_s) begin
          l_n.miso = 1'b1;
          l_n.st = csi_pkg::L_HUNT;
        end
      end
      // Unused codes fall back to hunting
      default: begin
        l_n.st = csi_pkg::L_HUNT;
      end
    endcase
    // Synchronised reset returns the link to hunting
    if (!l.rst_s) begin
      l_n.st = csi_pkg::L_HUNT;
      l_n.miso = 1'b1;
      l_n.ftg = 1'b0;
      l_n.bcnt = 6'h00;
    end
  end

  // Link registers
  always_ff @(posedge link_clk_i) begin
    l <= l_n;
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  assign serial_data_output_o = l.miso;
  // Released while deselected
  assign serial_data_output_oe_o = !link_cs_b_i;
  assign card_idle_o = s.idle;
  assign card_busy_o = s.busy;
  assign cmd_act_o = s.act;

  ////////////////////////////////////////////////////////////////////
  // Assertions

  // Accepted frame with a given index
  sequence s_take_ok(logic [5:0] c);
    take && !bad && (idx == c);
  endsequence

  // Frame of any index
  sequence s_take_any;
    take;
  endsequence

  a_reset_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_take_ok(`CSI_CMD_RESET) |=> s.idle && !s.init_run && !s.busy) // R1
    else $error("reset command did not enter idle");

  a_idle_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    take && s.idle && !idle_legal(idx) |=>
      s.rsp.bytes[32+`CSI_RB_ILLEGAL] && !s.act.valid) // R2
    else $error("idle card accepted a command");

  a_init_short: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_take_ok(`CSI_CMD_INIT) |=> s.rsp.nbytes == 3'h1 && !s.act.valid &&
      (s.init_run || !s.idle)) // R3
    else $error("init answer is not one byte");

  a_ocr_any: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    take && !crc_bad && !frame_bad && idx == `CSI_CMD_OCR |=>
      s.rsp.nbytes == 3'h5 && s.rsp.bytes[31:0] == OCR_VALUE) // R4
    else $error("conditions read refused");

  a_always_answer: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_take_any |=> s.rtg != $past(s.rtg)) // R6
    else $error("frame left without response");

  a_crc_reject: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    take && crc_bad |=> s.rsp.bytes[32+`CSI_RB_CRC] && !s.act.valid) // R7
    else $error("bad CRC not rejected");

  a_unsup_reject: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    take && !supported(idx) |=>
      s.rsp.bytes[32+`CSI_RB_ILLEGAL] && !s.act.valid) // R25
    else $error("unsupported index acted upon");

  a_busy_cmds: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (s_take_ok(`CSI_CMD_WR_ONE) or s_take_ok(`CSI_CMD_LOCK)) |=>
      s.busy && s.rsp.busy && s.act.valid) // R8
    else $error("write or lock without busy");

  a_blklen_set: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_take_ok(`CSI_CMD_BLKLEN) |=> s.blk_len == $past(arg)) // R17
    else $error("block length not stored");

  a_status_two: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    s_take_ok(`CSI_CMD_STATUS) |=> s.rsp.nbytes == 3'h2 &&
      s.rsp.bytes[31:24] == $past(status_byte_i)) // R16
    else $error("status answer malformed");

  a_busy_low: assert property (@(posedge link_clk_i) disable iff (!l.rst_s)
    l.st == csi_pkg::L_BUSY && l.bsy_s |=> !l.miso) // R24
    else $error("data line not low while busy");

  a_frame_len: assert property (@(posedge link_clk_i) disable iff (!l.rst_s)
    l.st == csi_pkg::L_CMD && l.bcnt == `CSI_FRM_LAST && !link_cs_b_i |=>
      l.st == csi_pkg::L_WAIT && l.ftg != $past(l.ftg)) // R9
    else $error("frame not closed after 48 bits");

endmodule
`default_nettype wire

// *** core/csi_cfg.svh ***
// Field positions, command codes, reset values and timing figures of the card command interpreter
`ifndef CSI_CFG_SVH
`define CSI_CFG_SVH
// Command frame layout, sent most significant bit first
`define CSI_FRM_LAST 6'h2f
`define CSI_TX_BIT 46
`define CSI_IDX_HI 45
`define CSI_IDX_LO 40
`define CSI_ARG_HI 39
`define CSI_ARG_LO 8
`define CSI_CRC_HI 7
`define CSI_CRC_LO 1
`define CSI_END_BIT 0
// Command indices
`define CSI_CMD_RESET 6'h00
`define CSI_CMD_INIT 6'h01
`define CSI_CMD_CSD 6'h09
`define CSI_CMD_CID 6'h0a
`define CSI_CMD_STATUS 6'h0d
`define CSI_CMD_BLKLEN 6'h10
`define CSI_CMD_RD_ONE 6'h11
`define CSI_CMD_RD_MULTI 6'h12
`define CSI_CMD_BLKCNT 6'h17
`define CSI_CMD_WR_ONE 6'h18
`define CSI_CMD_LOCK 6'h2a
`define CSI_CMD_OCR 6'h3a
// Short response bit positions
`define CSI_RB_IDLE 0
`define CSI_RB_ILLEGAL 2
`define CSI_RB_CRC 3
`define CSI_RB_PARAM 6
// Reset values
`define CSI_BLK_LEN_RST 32'h00000200
`define CSI_MAX_BLK_LEN 2048
`define CSI_OCR_RST 32'h00ff8000
// Internal initialisation time
`define CSI_CLK_MHZ 125
`define CSI_INIT_TIME_NS 1000
`define CSI_INIT_CYC ((`CSI_INIT_TIME_NS * `CSI_CLK_MHZ + 999) / 1000)
`endif

// *** core/csi_pkg.sv ***
// Types shared by the card command interpreter
package csi_pkg;
  // Action handed to the storage back end
  typedef enum logic [2:0] {
    ACT_CSD, ACT_CID, ACT_RD_ONE, ACT_RD_MULTI, ACT_WR_ONE, ACT_LOCK
  } csi_act_t;
  typedef struct packed {
    logic valid;
    csi_act_t kind;
    logic [31:0] addr;
    logic [31:0] blk_len;
    logic [15:0] blk_cnt;
  } csi_cmd_act_t;
  // Response handed from system side to link side
  typedef struct packed {
    logic [39:0] bytes;
    logic [2:0] nbytes;
    logic busy;
  } csi_rsp_t;
  // Link side states
  typedef enum logic [2:0] {L_HUNT, L_CMD, L_WAIT, L_RSP, L_BUSY} csi_lstate_t;
  // Link clock domain state
  typedef struct packed {
    logic rst_m;
    logic rst_s;
    csi_lstate_t st;
    logic [47:0] frame;
    logic ftg;
    logic rtg_m;
    logic rtg_s;
    logic rtg_d;
    logic bsy_m;
    logic bsy_s;
    logic [5:0] bcnt;
    logic [39:0] osh;
    logic miso;
  } csi_link_t;
  // System clock domain state
  typedef struct packed {
    logic ftg_m;
    logic ftg_s;
    logic ftg_d;
    logic rtg;
    csi_rsp_t rsp;
    logic idle;
    logic init_run;
    logic [15:0] init_cnt;
    logic busy;
    logic [31:0] blk_len;
    logic pend_vld;
    logic [15:0] pend_cnt;
    csi_cmd_act_t act;
  } csi_sys_t;
endpackage

// *** dv/csi_host.sv ***
// Host controller model that clocks command frames into the card and collects replies
`timescale 1ns/1ps
`default_nettype none
module csi_host (
  // Link toward the card
  output logic link_clk_o,
  output logic link_cs_b_o,
  output logic link_mosi_o,
  input wire logic link_miso_i
);
  // Line value seen just before the last rising edge
  logic s;
  // Clears the end bit of frames while set
  logic cut_end;

  // Link idles deselected, clock parked low
  initial begin
    link_clk_o = 1'b0;
    link_cs_b_o = 1'b1;
    link_mosi_o = 1'b1;
    s = 1'b1;
    cut_end = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // One 15 ns link period: sample before the rise, drive after it
  task automatic tick(input logic nb);
    #7 s = link_miso_i;
    #0.5 link_clk_o = 1'b1;
    #1 link_mosi_o = nb;
    #6.5 link_clk_o = 1'b0;
  endtask

  // Free clocking with filler ones
  task automatic run(input int n);
    repeat (n) tick(1'b1);
  endtask

  // Select, clock filler, report last level seen, deselect
  task automatic poll(input int n, output logic lvl);
    link_cs_b_o = 1'b0;
    run(n);
    lvl = s;
    link_cs_b_o = 1'b1;
  endtask

  // Seven-bit check over the first forty frame bits
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    logic fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
    end
    return c;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Whole exchange: frame out, hunt the first zero, collect nb bytes
  task automatic xfer(input logic [5:0] idx, input logic [31:0] arg, input logic bad,
                      input int nb, output logic [39:0] rsp);
    logic [47:0] f;
    int k;
    // Start, transmission, index, argument, check, end bits
    f = {2'b01, idx, arg, crc7({2'b01, idx, arg}) ^ {6'h00, bad}, ~cut_end};
    link_cs_b_o = 1'b0;
    link_mosi_o = f[47];
    // Most significant bit first, 48 bits
    for (int i = 47; i > 0; i--) begin
      tick(f[i-1]);
    end
    tick(1'b1);
    // Bounded hunt for the reply's leading zero
    k = 0;
    while (s !== 1'b0 && k < 16) begin
      tick(1'b1);
      k++;
    end
    rsp = {39'h0, s};
    repeat (nb * 8 - 1) begin
      tick(1'b1);
      rsp = {rsp[38:0], s};
    end
    tick(1'b1);
    link_cs_b_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// *** dv/csi_core_bench.sv ***
// Self-checking bench of the card command interpreter against a host model
`timescale 1ns/1ps
`default_nettype none
module csi_core_bench;
  localparam logic [31:0] OPERATING_CONDITIONS_REG = 32'h00ff8000;
  // System side stimulus and observation
  logic clk_sys_i, rst_b_i, crc_check_en_i, op_done_i, lvl;
  logic [7:0] status_byte_i;
  logic link_clk, link_cs_b, link_mosi, sdo, sdo_oe, card_idle, card_busy;
  wire logic miso;
  csi_pkg::csi_cmd_act_t act, last_act;
  int n_fail = 0, samples_checked = 0, n_act = 0, n_before, seed, k;
  logic [39:0] r;
  logic [31:0] blen, addr;
  logic [15:0] cnt;
  logic [5:0] bad_idx [17] = '{6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h0b,
    6'h0c, 6'h0e, 6'h0f, 6'h13, 6'h14, 6'h15, 6'h16, 6'h19, 6'h3f};

  // Pull-up holds a released data line high
  assign miso = sdo_oe ? sdo : 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  // Design and host
  csi_core #(.INIT_CYCLES(4), .MAX_BLK_LEN(2048), .OCR_VALUE(OPERATING_CONDITIONS_REG)) u_dut (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .link_clk_i(link_clk),
    .link_cs_b_i(link_cs_b), .link_mosi_i(link_mosi), .serial_data_output_o(sdo),
    .serial_data_output_oe_o(sdo_oe), .crc_check_en_i(crc_check_en_i),
    .status_byte_i(status_byte_i), .card_idle_o(card_idle), .card_busy_o(card_busy),
    .cmd_act_o(act), .op_done_i(op_done_i));
  csi_host u_host (.link_clk_o(link_clk), .link_cs_b_o(link_cs_b),
    .link_mosi_o(link_mosi), .link_miso_i(miso));

  // System clock, 8 ns
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  // Action monitor
  always @(posedge clk_sys_i) begin
    if (act.valid === 1'b1) begin
      n_act <= n_act + 1;
      last_act <= act;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Expected short reply byte
  function automatic logic [39:0] r1(input logic idle, ill, crc, par);
    return {32'h0, 1'b0, par, 2'b00, crc, ill, 1'b0, idle};
  endfunction

  // One command, remembering the action count before it
  task automatic cmd(input logic [5:0] idx, input logic [31:0] arg, input logic bad, input int nb);
    n_before = n_act;
    u_host.xfer(idx, arg, bad, nb, r);
    @(posedge clk_sys_i);
    #1;
  endtask

  // Action count since the last command
  function automatic logic [39:0] nact();
    return 40'(n_act - n_before);
  endfunction

  task automatic report_and_stop;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #200000;
    n_fail++;
    report_and_stop;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    seed = 9;
    rst_b_i = 1'b0;
    crc_check_en_i = 1'b0;
    op_done_i = 1'b0;
    status_byte_i = 8'h00;
    // Both domains clocked through reset
    fork
      repeat (3) @(posedge clk_sys_i);
      u_host.run(4);
    join
    @(posedge clk_sys_i);
    #1 rst_b_i = 1'b1;
    u_host.run(6);
    chk("idle_after_reset", {39'h0, card_idle}, 40'h1);
    // Idle refuses a read, takes conditions read
    cmd(6'h11, 32'h0, 1'b0, 1);
    chk("idle_read_rsp", r, r1(1, 1, 0, 0));
    chk("idle_read_act", nact(), 40'h0);
    cmd(6'h3a, 32'h0, 1'b0, 5);
    chk("ocr_idle", r, {8'h01, OPERATING_CONDITIONS_REG});
    // Initialisation polling, zero argument
    cmd(6'h01, 32'h0, 1'b0, 1);
    chk("init_first", r, r1(1, 0, 0, 0));
    k = 0;
    while (r[0] !== 1'b0 && k < 8) begin
      cmd(6'h01, 32'h0, 1'b0, 1);
      k++;
    end
    chk("init_done", r, r1(0, 0, 0, 0));
    chk("idle_cleared", {39'h0, card_idle}, 40'h0);
    cmd(6'h3a, 32'h0, 1'b0, 5);
    chk("ocr_ready", r, {8'h00, OPERATING_CONDITIONS_REG});
    // Unsupported and reserved indices
    foreach (bad_idx[i]) begin
      cmd(bad_idx[i], $random(seed), 1'b0, 1);
      chk("unsup_rsp", r, r1(0, 1, 0, 0));
      chk("unsup_act", nact(), 40'h0);
    end
    // Block length bounds
    cmd(6'h10, 32'h0, 1'b0, 1);
    chk("blen_zero", r, r1(0, 0, 0, 1));
    cmd(6'h10, 32'h00000801, 1'b0, 1);
    chk("blen_big", r, r1(0, 0, 0, 1));
    // Random lengths and single reads
    repeat (3) begin
      blen = 32'h1 + ($random(seed) & 32'h7ff);
      addr = $random(seed);
      cmd(6'h10, blen, 1'b0, 1);
      chk("blen_rsp", r, r1(0, 0, 0, 0));
      cmd(6'h11, addr, 1'b0, 1);
      chk("rd_rsp", r, r1(0, 0, 0, 0));
      chk("rd_act", nact(), 40'h1);
      chk("rd_kind", {37'h0, last_act.kind}, {37'h0, csi_pkg::ACT_RD_ONE});
      chk("rd_addr", {8'h0, last_act.addr}, {8'h0, addr});
      chk("rd_len", {8'h0, last_act.blk_len}, {8'h0, blen});
    end
    // Counted then open-ended multi read
    cnt = 16'($random(seed));
    cmd(6'h17, {16'h0, cnt}, 1'b0, 1);
    chk("cnt_rsp", r, r1(0, 0, 0, 0));
    cmd(6'h12, addr, 1'b0, 1);
    chk("multi_kind", {37'h0, last_act.kind}, {37'h0, csi_pkg::ACT_RD_MULTI});
    chk("multi_cnt", {24'h0, last_act.blk_cnt}, {24'h0, cnt});
    cmd(6'h12, addr, 1'b0, 1);
    chk("open_cnt", {24'h0, last_act.blk_cnt}, 40'h0);
    cmd(6'h17, 32'h00010004, 1'b0, 1);
    chk("cnt_high", r, r1(0, 0, 0, 1));
    // Status fetch, two bytes
    status_byte_i = 8'($random(seed));
    cmd(6'h0d, 32'h0, 1'b0, 2);
    chk("status_rsp", r, {32'h0, 8'h00, status_byte_i});
    // Register reads
    cmd(6'h09, 32'h0, 1'b0, 1);
    chk("csd_kind", {37'h0, last_act.kind}, {37'h0, csi_pkg::ACT_CSD});
    cmd(6'h0a, 32'h0, 1'b0, 1);
    chk("cid_rsp", r, r1(0, 0, 0, 0));
    chk("cid_kind", {37'h0, last_act.kind}, {37'h0, csi_pkg::ACT_CID});
    // Write and lock: short reply then busy low
    for (int j = 0; j < 2; j++) begin
      cmd(j ? 6'h2a : 6'h18, $random(seed), 1'b0, 1);
      chk("busy_rsp", r, r1(0, 0, 0, 0));
      chk("busy_kind", {37'h0, last_act.kind},
          {37'h0, j ? csi_pkg::ACT_LOCK : csi_pkg::ACT_WR_ONE});
      chk("busy_flag", {39'h0, card_busy}, 40'h1);
      u_host.poll(8, lvl);
      chk("busy_line", {39'h0, lvl}, 40'h0);
      @(posedge clk_sys_i);
      #1 op_done_i = 1'b1;
      @(posedge clk_sys_i);
      #1 op_done_i = 1'b0;
      u_host.poll(8, lvl);
      chk("busy_end", {39'h0, lvl}, 40'h1);
      chk("busy_clear", {39'h0, card_busy}, 40'h0);
    end
    // Check-protected frames
    crc_check_en_i = 1'b1;
    cmd(6'h09, 32'h0, 1'b1, 1);
    chk("crc_bad", r, r1(0, 0, 1, 0));
    chk("crc_bad_act", nact(), 40'h0);
    cmd(6'h09, 32'h0, 1'b0, 1);
    chk("crc_good_act", nact(), 40'h1);
    crc_check_en_i = 1'b0;
    // Frame with a cleared end bit
    u_host.cut_end = 1'b1;
    cmd(6'h11, addr, 1'b0, 1);
    chk("end_bit_rsp", r, r1(0, 1, 0, 0));
    chk("end_bit_act", nact(), 40'h0);
    u_host.cut_end = 1'b0;
    // Software reset back to idle
    cmd(6'h00, 32'h0, 1'b0, 1);
    chk("reset_rsp", r, r1(1, 0, 0, 0));
    chk("reset_idle", {39'h0, card_idle}, 40'h1);
    report_and_stop;
  end
endmodule
`default_nettype wire
